/* File: shared/serial_port_pkg.sv */
// Constants, register map and state types of the serial port
package serial_port_pkg;
	// Bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_BAUD  = 8'h04;
	localparam logic [7:0] OFF_FRAC  = 8'h08;
	localparam logic [7:0] OFF_TXBUF = 8'h0c;
	localparam logic [7:0] OFF_RXBUF = 8'h10;
	localparam logic [7:0] OFF_STAT  = 8'h14;

	// Control register fields
	localparam int CTRL_W  = 10;
	localparam int B_EN    = 0;
	localparam int B_SYNC  = 1;
	localparam int B_NINE  = 2;
	localparam int B_PAR   = 3;
	localparam int B_ODD   = 4;
	localparam int B_STOP2 = 5;
	localparam int B_MPROC = 6;
	localparam int B_LOOP  = 7;
	localparam int B_REN   = 8;
	localparam int B_FRAC  = 9;
	localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

	// Baud reload and fractional step
	localparam int BAUD_W = 13;
	localparam int FRAC_W = 10;
	localparam logic [BAUD_W-1:0] BAUD_RST = 13'h0000;
	localparam logic [FRAC_W-1:0] FRAC_RST = 10'h000;

	// Status register fields
	localparam int S_TXEMPTY = 0;
	localparam int S_TXBUSY  = 1;
	localparam int S_RXFULL  = 2;
	localparam int S_PERR    = 3;
	localparam int S_FERR    = 4;
	localparam int S_OERR    = 5;
	localparam int S_RXADDR  = 6;

	// Tick counts within one bit
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [3:0] SAMP_A    = 4'h7;
	localparam logic [3:0] SAMP_B    = 4'h8;
	localparam logic [3:0] SAMP_C    = 4'h9;
	localparam logic [3:0] SYNC_LAST = 4'h7;
	localparam logic [3:0] SYNC_RISE = 4'h4;

	// Frame lengths in bits
	localparam logic [3:0] LEN_SYNC = 4'h8;
	localparam logic [3:0] LEN_BASE = 4'ha;
	localparam logic [3:0] RX_BITS8 = 4'h8;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01,
		TX_END   = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11,
		RX_STOP  = 2'b10
	} rx_state_t;
endpackage

/* File: verilog/baud_gen.sv */
// Fractional prescaler followed by a 13-bit reload counter
`timescale 1ns/10ps
module baud_gen (
	input  wire logic                              clk,    // Module clock
	input  wire logic                              rst,    // Async reset, high
	input  wire logic                              run,    // Port enabled
	input  wire logic                              fracEn, // Use fractional prescaler
	input  wire logic [serial_port_pkg::BAUD_W-1:0] reload, // Reload value
	input  wire logic [serial_port_pkg::FRAC_W-1:0] step,   // Step of fractional divider
	output logic                                   tick    // One-cycle rate pulse
);
	import serial_port_pkg::*;

	logic [FRAC_W-1:0] acc;
	logic              pre;
	logic [BAUD_W-1:0] cnt;

	// Accumulator carry gives step/1024 of the clock, for fine rate trim
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= FRAC_RST;
			pre <= 1'b0;
		end else if (!run) begin
			acc <= FRAC_RST;
			pre <= 1'b0;
		end else if (fracEn) begin
			{pre, acc} <= {1'b0, acc} + {1'b0, step};
		end else begin
			pre <= 1'b1;
		end
	end

	// Reload counter; reload 0 gives one tick per prescaled clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt  <= BAUD_RST;
			tick <= 1'b0;
		end else if (!run) begin
			cnt  <= BAUD_RST;
			tick <= 1'b0;
		end else begin
			tick <= pre && (cnt == BAUD_RST);
			if (pre) begin
				if (cnt == BAUD_RST)
					cnt <= reload;
				else
					cnt <= cnt - 13'h0001;
			end
		end
	end
endmodule // baud_gen

/* File: verilog/async_sync_serial_port.sv */
// Serial port top: APB registers, transmitter, receiver, pins
`timescale 1ns/10ps
module async_sync_serial_port (
	input  wire logic                              clk,       // Module clock
	input  wire logic                              rst,       // Async reset, high
	input  wire logic                              psel,      // APB select
	input  wire logic                              penable,   // APB enable
	input  wire logic                              pwrite,    // APB write
	input  wire logic [serial_port_pkg::ADDR_W-1:0] paddr,     // APB address
	input  wire logic [serial_port_pkg::DATA_W-1:0] pwdata,    // APB write data
	output logic      [serial_port_pkg::DATA_W-1:0] prdata,    // APB read data
	output logic                                   pready,    // APB ready
	output logic                                   pslverr,   // APB error
	input  wire logic                              rxdIn,     // Receive / sync data in
	output logic                                   rxdOut,    // Sync data out
	output logic                                   rxdOeN,    // Sync data enable, low
	output logic                                   txd,       // Async data / sync clock
	output logic                                   irqTxBuf,  // Transmit buffer empty
	output logic                                   irqTxLast, // Last bit shifted out
	output logic                                   irqRxFull, // Receive buffer full
	output logic                                   irqErr     // Receive error
);
	import serial_port_pkg::*;

	logic [CTRL_W-1:0] ctrl;
	logic [BAUD_W-1:0] baud;
	logic [FRAC_W-1:0] frac;
	logic              tick;
	logic [8:0]        txBuf;
	logic              txFull;
	logic [8:0]        rxBuf;
	logic              rxFull;
	logic              perr;
	logic              ferr;
	logic              oerr;
	logic              rxAddr;
	logic              newSince;
	tx_state_t         txState;
	logic [11:0]       txSh;
	logic [3:0]        txLeft;
	logic [3:0]        txCnt;
	logic              dirRx;
	logic [7:0]        syncSh;
	logic              syncDone;
	logic              txLast;
	rx_state_t         rxState;
	logic [3:0]        rxCnt;
	logic [3:0]        rxBits;
	logic [8:0]        rxSh;
	logic [1:0]        samp;
	logic              asyncDone;
	logic              asyncFerr;
	logic              rxdReg;

	// Mode decode
	logic en, sync, nine, par, odd, stop2, mproc, loop, ren;
	assign en    = ctrl[B_EN];
	assign sync  = ctrl[B_SYNC];
	assign nine  = ctrl[B_NINE];
	assign par   = ctrl[B_PAR];
	assign odd   = ctrl[B_ODD];
	assign stop2 = ctrl[B_STOP2];
	assign mproc = ctrl[B_MPROC];
	assign loop  = ctrl[B_LOOP];
	assign ren   = ctrl[B_REN];

	// Bus phases; pready is set in setup so access lasts one cycle
	logic setup, wrEn, rdEn, mapped;
	assign setup  = psel && !penable;
	assign wrEn   = psel && penable && pready && pwrite;
	assign rdEn   = psel && penable && pready && !pwrite;
	assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_BAUD) || (paddr == OFF_FRAC) ||
		(paddr == OFF_TXBUF) || (paddr == OFF_RXBUF) || (paddr == OFF_STAT);

	baud_gen u_baud (
		.clk    (clk),
		.rst    (rst),
		.run    (en),
		.fracEn (ctrl[B_FRAC]),
		.reload (baud),
		.step   (frac),
		.tick   (tick)
	);

	// Configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RST;
			baud <= BAUD_RST;
			frac <= FRAC_RST;
		end else if (wrEn) begin
			if (paddr == OFF_CTRL)
				ctrl <= pwdata[CTRL_W-1:0];
			if (paddr == OFF_BAUD)
				baud <= pwdata[BAUD_W-1:0];
			if (paddr == OFF_FRAC)
				frac <= pwdata[FRAC_W-1:0];
		end
	end

	// Read data captured in setup, so it is stable through access
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				case (paddr)
					OFF_CTRL:  prdata <= {22'h000000, ctrl};
					OFF_BAUD:  prdata <= {19'h00000, baud};
					OFF_FRAC:  prdata <= {22'h000000, frac};
					OFF_TXBUF: prdata <= {23'h000000, txBuf};
					OFF_RXBUF: prdata <= {23'h000000, rxBuf};
					OFF_STAT:  prdata <= {25'h0000000, rxAddr, oerr, ferr, perr, rxFull,
						(txState != TX_IDLE), !txFull};
					default:   prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Transmit holding buffer; a write while full is dropped unless the buffer is taken in that cycle
	logic txTake, syncRxGo, txWr;
	assign txTake   = en && (txState == TX_IDLE) && txFull;
	assign syncRxGo = en && sync && ren && (txState == TX_IDLE) && !txFull;
	assign txWr     = wrEn && (paddr == OFF_TXBUF) && (!txFull || txTake);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txBuf  <= 9'h000;
			txFull <= 1'b0;
		end else if (txWr) begin
			txBuf  <= pwdata[8:0];
			txFull <= 1'b1;
		end else if (txTake) begin
			txFull <= 1'b0;
		end
	end

	// Frame image and length; ninth slot is a stop bit in 8-bit frames
	logic       ninthTx;
	logic [3:0] txLen;
	logic [3:0] bitLast;
	logic       rxLine;
	assign ninthTx = !nine ? 1'b1 : (par ? (^txBuf[7:0]) ^ odd : txBuf[8]);
	assign txLen   = LEN_BASE + {3'h0, nine} + {3'h0, stop2};
	assign bitLast = sync ? SYNC_LAST : OVS_LAST;
	assign rxLine  = loop ? (sync ? rxdOut : txd) : rxdReg;

	// Shared shifter: async transmit, or sync transmit or receive
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txState  <= TX_IDLE;
			txSh     <= 12'hfff;
			txLeft   <= 4'h0;
			txCnt    <= 4'h0;
			dirRx    <= 1'b0;
			syncSh   <= 8'h00;
			syncDone <= 1'b0;
			txLast   <= 1'b0;
		end else if (!en) begin
			txState  <= TX_IDLE;
			txSh     <= 12'hfff;
			syncDone <= 1'b0;
			txLast   <= 1'b0;
		end else begin
			syncDone <= 1'b0;
			txLast   <= 1'b0;
			case (txState)
				TX_IDLE: begin
					txCnt <= 4'h0;
					if (txTake) begin
						if (sync)
							txSh <= {4'hf, txBuf[7:0]};
						else
							txSh <= {2'b11, ninthTx, txBuf[7:0], 1'b0};
						txLeft  <= sync ? LEN_SYNC : txLen;
						dirRx   <= 1'b0;
						txState <= TX_SHIFT;
					end else if (syncRxGo) begin
						txSh    <= 12'hfff;
						txLeft  <= LEN_SYNC;
						dirRx   <= 1'b1;
						txState <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (tick) begin
						txCnt <= (txCnt == bitLast) ? 4'h0 : txCnt + 4'h1;
						// Sample on the rising shift clock edge
						if (sync && dirRx && (txCnt == SYNC_RISE))
							syncSh <= {rxLine, syncSh[7:1]};
						if (txCnt == bitLast) begin
							txSh   <= {1'b1, txSh[11:1]};
							txLeft <= txLeft - 4'h1;
							if (txLeft == 4'h1)
								txState <= TX_END;
						end
					end
				end
				TX_END: begin
					syncDone <= sync && dirRx;
					txLast   <= !dirRx;
					txState  <= TX_IDLE;
				end
				default: txState <= TX_IDLE;
			endcase
		end
	end

	// Pins; in sync mode the data pin is driven only while sending
	logic syncAct;
	assign syncAct = sync && (txState == TX_SHIFT);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txd    <= 1'b1;
			rxdOut <= 1'b1;
			rxdOeN <= 1'b1;
			rxdReg <= 1'b1;
		end else begin
			rxdReg <= rxdIn;
			if (syncAct)
				txd <= (txCnt >= SYNC_RISE);
			else if (txState == TX_SHIFT)
				txd <= txSh[0];
			else
				txd <= 1'b1;
			rxdOut <= txSh[0];
			rxdOeN <= !(syncAct && !dirRx);
		end
	end

	// Async receiver, majority of three samples around mid-bit
	logic       bitVal;
	logic [3:0] rxLen;
	assign bitVal = (samp[0] & samp[1]) | (samp[0] & rxLine) | (samp[1] & rxLine);
	assign rxLen  = RX_BITS8 + {3'h0, nine};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxState   <= RX_IDLE;
			rxCnt     <= 4'h0;
			rxBits    <= 4'h0;
			rxSh      <= 9'h000;
			samp      <= 2'b11;
			asyncDone <= 1'b0;
			asyncFerr <= 1'b0;
		end else if (!en || sync || !ren) begin
			rxState   <= RX_IDLE;
			asyncDone <= 1'b0;
		end else begin
			asyncDone <= 1'b0;
			if (tick) begin
				rxCnt <= rxCnt + 4'h1;
				if (rxCnt == SAMP_A)
					samp[0] <= rxLine;
				if (rxCnt == SAMP_B)
					samp[1] <= rxLine;
				case (rxState)
					RX_IDLE: begin
						rxCnt  <= 4'h0;
						rxBits <= 4'h0;
						if (!rxLine)
							rxState <= RX_START;
					end
					RX_START: begin
						// A short low pulse is a glitch, not a start bit
						if (rxCnt == SAMP_C)
							rxState <= bitVal ? RX_IDLE : RX_DATA;
					end
					RX_DATA: begin
						if (rxCnt == SAMP_C) begin
							rxSh   <= {bitVal, rxSh[8:1]};
							rxBits <= rxBits + 4'h1;
							if (rxBits == rxLen - 4'h1)
								rxState <= RX_STOP;
						end
					end
					RX_STOP: begin
						// Only the first stop bit is checked
						if (rxCnt == SAMP_C) begin
							asyncDone <= 1'b1;
							asyncFerr <= !bitVal;
							rxState   <= RX_IDLE;
						end
					end
					default: rxState <= RX_IDLE;
				endcase
			end
		end
	end

	// Delivery into the receive buffer from either mode
	logic       deliver;
	logic [8:0] rxWord;
	logic       peNew, feNew, oeNew, addrNew, rdClr;
	assign deliver = asyncDone || syncDone;
	assign rxWord  = syncDone ? {1'b0, syncSh} : (nine ? rxSh : {1'b0, rxSh[8:1]});
	assign peNew   = asyncDone && nine && par && ((^rxSh) ^ odd);
	assign feNew   = asyncDone && asyncFerr;
	assign oeNew   = deliver && rxFull;
	assign addrNew = asyncDone && nine && !par && mproc && rxSh[8];
	assign rdClr   = rdEn && (paddr == OFF_RXBUF) && !newSince;

	// Receive buffer; a word arriving mid-read keeps its full flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxBuf    <= 9'h000;
			rxFull   <= 1'b0;
			rxAddr   <= 1'b0;
			newSince <= 1'b0;
		end else begin
			if (deliver) begin
				rxBuf  <= rxWord;
				rxAddr <= addrNew;
				rxFull <= 1'b1;
			end else if (rdClr) begin
				rxFull <= 1'b0;
			end
			if (setup)
				newSince <= deliver; // A word landing at setup was not captured
			else if (deliver)
				newSince <= 1'b1;
		end
	end

	// Error flags, write one to clear; a new error wins over the clear
	logic stClr;
	assign stClr = wrEn && (paddr == OFF_STAT);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			perr <= 1'b0;
			ferr <= 1'b0;
			oerr <= 1'b0;
		end else begin
			if (peNew)
				perr <= 1'b1;
			else if (stClr && pwdata[S_PERR])
				perr <= 1'b0;
			if (feNew)
				ferr <= 1'b1;
			else if (stClr && pwdata[S_FERR])
				ferr <= 1'b0;
			if (oeNew)
				oerr <= 1'b1;
			else if (stClr && pwdata[S_OERR])
				oerr <= 1'b0;
		end
	end

	// Request pulses, one cycle each
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqTxBuf  <= 1'b0;
			irqTxLast <= 1'b0;
			irqRxFull <= 1'b0;
			irqErr    <= 1'b0;
		end else begin
			irqTxBuf  <= txTake;
			irqTxLast <= txLast;
			irqRxFull <= deliver;
			irqErr    <= peNew || feNew || oeNew;
		end
	end
endmodule // async_sync_serial_port

/* File: verif/serial_port_asserts.sv */
// Boundary checks of the serial port: bus handshake and request pulses
`timescale 1ns/10ps
module serial_port_asserts
	import serial_port_pkg::*;
(
	input wire logic                               clk,       // Module clock
	input wire logic                               rst,       // Async reset, high
	input wire logic                               psel,      // Bus select
	input wire logic                               penable,   // Bus enable
	input wire logic                               pwrite,    // Bus write
	input wire logic [serial_port_pkg::ADDR_W-1:0] paddr,     // Bus address
	input wire logic [serial_port_pkg::DATA_W-1:0] prdata,    // Read data
	input wire logic                               pready,    // Ready
	input wire logic                               pslverr,   // Error
	input wire logic                               rxdOeN,    // Data enable, low
	input wire logic                               txd,       // Line or shift clock
	input wire logic                               irqTxBuf,  // Buffer empty
	input wire logic                               irqTxLast, // Last bit sent
	input wire logic                               irqRxFull, // Buffer full
	input wire logic                               irqErr     // Receive error
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic setup;
	logic mapped;
	// Setup phase and decoded address; everything else must be refused
	assign setup  = psel && !penable;
	assign mapped = paddr inside {OFF_CTRL, OFF_BAUD, OFF_FRAC, OFF_TXBUF, OFF_RXBUF, OFF_STAT};

	chk_ready_access: assert property (setup |=> pready)
		else $error("ready missing in access cycle");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held past access");
	chk_ready_cause: assert property (pready |-> $past(setup))
		else $error("ready without setup");
	chk_unmapped_err: assert property (setup && !mapped && !pwrite |=> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	chk_mapped_ok: assert property (setup && mapped |=> !pslverr)
		else $error("error on mapped register");
	chk_txbuf_pulse: assert property (irqTxBuf |=> !irqTxBuf)
		else $error("buffer empty request too long");
	chk_last_pulse: assert property (irqTxLast |=> !irqTxLast)
		else $error("last bit request too long");
	chk_rxfull_gap: assert property (irqRxFull |=> !irqRxFull [*8])
		else $error("receive requests too close");
	chk_err_delivery: assert property (irqErr |-> irqRxFull)
		else $error("error request without delivery");
	chk_reset_idle: assert property ($past(rst) |-> txd && rxdOeN && !irqTxLast)
		else $error("pins not idle after reset");
endmodule // serial_port_asserts

bind async_sync_serial_port serial_port_asserts i_serial_port_asserts (.clk, .rst, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .rxdOeN, .txd, .irqTxBuf,
	.irqTxLast, .irqRxFull, .irqErr);

/* File: verif/serial_peer.sv */
// Far-side peer: sends asynchronous frames and captures the port's frames
`timescale 1ns/10ps
module serial_peer #(
	parameter int BIT = 16
) (
	input  wire logic clk, // Module clock
	input  wire logic txd, // Line from the port
	output logic      rxd  // Line into the port
);
	logic [10:0] got;   // Last captured bits, stop included
	int          n = 9; // Bits captured after the start bit
	// Idle mark level; the line is held high between frames
	initial rxd = 1'b1;

	// Start bit, then the given bits LSB first, then idle mark
	task automatic send(input logic [10:0] bits, input int nb);
		@(posedge clk);
		rxd <= 1'b0;
		repeat (BIT) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			rxd <= bits[i];
			repeat (BIT) @(posedge clk);
		end
		rxd <= 1'b1;
		repeat (2 * BIT) @(posedge clk);
	endtask

	// Mid-bit sampling after each falling start edge
	initial begin
		forever begin
			@(negedge txd);
			repeat (BIT / 2) @(posedge clk);
			for (int i = 0; i < n; i++) begin
				repeat (BIT) @(posedge clk);
				got[i] = txd;
			end
		end
	end
endmodule // serial_peer

/* File: verif/tb_top.sv */
// Self-checking testbench of the serial port
`timescale 1ns/10ps
module tb_top;
	import serial_port_pkg::*;
	logic        clk, rst, psel, penable, pwrite, rxdIn;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, rxdOut, rxdOeN, txd;
	logic        irqTxBuf, irqTxLast, irqRxFull, irqErr;
	int          fail_count, n_checks, nRx, nErr;

	async_sync_serial_port i_async_sync_serial_port (.clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rxdIn, .rxdOut, .rxdOeN, .txd,
		.irqTxBuf, .irqTxLast, .irqRxFull, .irqErr);
	serial_peer i_serial_peer (.clk, .txd, .rxd(rxdIn));

	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Request pulse counters, sampled off the launching edge
	always @(negedge clk) begin
		nRx += int'(irqRxFull === 1'b1);
		nErr += int'(irqErr === 1'b1);
	end

	task automatic print_verdict();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic timeout();
		fail_count++;
		$display("CHECK FAILED %0t wait ran out", $time);
		print_verdict();
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus transfer; the request holds until ready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		if (k >= 20) timeout();
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_irq(input int which, input int lim);
		logic [3:0] v;
		for (int k = 0; k < lim; k++) begin
			@(negedge clk);
			v = {irqErr, irqRxFull, irqTxLast, irqTxBuf};
			if (v[which] === 1'b1) return;
		end
		timeout();
	endtask

	// Bounded wait for a line level, looked at off the launching edge
	task automatic wait_txd(input logic lvl, input int lim);
		for (int k = 0; k < lim; k++) begin
			if (txd === lvl) return;
			@(negedge clk);
		end
		timeout();
	endtask

	task automatic s_reset();
		@(negedge clk);
		cmp({31'h0, txd}, 32'h1);
		cmp({31'h0, rxdOeN}, 32'h1);
		apb(0, OFF_CTRL, 0);
		cmp(rd, {22'h0, CTRL_RST});
		apb(0, OFF_STAT, 0);
		cmp(rd, 32'h1);
		apb(1, OFF_BAUD, 32'hffffffff);
		apb(0, OFF_BAUD, 0);
		cmp(rd, 32'h1fff);
		apb(1, OFF_FRAC, 32'hffffffff);
		apb(0, OFF_FRAC, 0);
		cmp(rd, 32'h3ff);
		apb(0, 8'h18, 0);
		cmp({31'h0, err}, 32'h1);
		cmp(rd, 32'h0);
		apb(1, OFF_BAUD, 0);
	endtask

	task automatic s_tx();
		apb(1, OFF_CTRL, 32'h1);
		apb(1, OFF_TXBUF, 32'ha5);
		wait_irq(0, 10);
		apb(1, OFF_TXBUF, 32'h3c);
		wait_irq(1, 400);
		cmp({23'h0, i_serial_peer.got[8:0]}, 32'h1a5);
		wait_irq(1, 400);
		cmp({23'h0, i_serial_peer.got[8:0]}, 32'h13c);
	endtask

	task automatic s_rx();
		nRx = 0;
		i_serial_peer.send(9'h15a, 9);
		cmp(nRx, 0);
		apb(1, OFF_CTRL, 32'h101);
		i_serial_peer.send(9'h15a, 9);
		cmp(nRx, 1);
		apb(0, OFF_STAT, 0);
		cmp(rd, 32'h5);
		apb(0, OFF_RXBUF, 0);
		cmp(rd, 32'h5a);
		nErr = 0;
		i_serial_peer.send(9'h0c3, 9);
		cmp(nErr, 1);
		apb(0, OFF_STAT, 0);
		cmp(rd, 32'h15);
		apb(1, OFF_STAT, 32'h38);
		i_serial_peer.send(9'h181, 9);
		apb(0, OFF_STAT, 0);
		cmp(rd, 32'h25);
		apb(0, OFF_RXBUF, 0);
		cmp(rd, 32'h81);
		cmp(nErr, 2);
		apb(1, OFF_STAT, 32'h38);
	endtask

	task automatic s_parity();
		i_serial_peer.n = 10;
		apb(1, OFF_CTRL, 32'h10d);
		apb(1, OFF_TXBUF, 32'h07);
		wait_irq(1, 400);
		cmp({22'h0, i_serial_peer.got[9:0]}, 32'h307);
		i_serial_peer.send(10'h303, 10);
		apb(0, OFF_STAT, 0);
		cmp(rd, 32'hd);
		apb(1, OFF_STAT, 32'h38);
		apb(0, OFF_RXBUF, 0);
		apb(1, OFF_CTRL, 32'h11d);
		nErr = 0;
		i_serial_peer.send(10'h303, 10);
		apb(0, OFF_RXBUF, 0);
		cmp(rd, 32'h103);
		cmp(nErr, 0);
	endtask

	task automatic s_mproc();
		apb(1, OFF_CTRL, 32'h145);
		i_serial_peer.send(10'h342, 10);
		apb(0, OFF_STAT, 0);
		cmp(rd, 32'h45);
		apb(0, OFF_RXBUF, 0);
		cmp(rd, 32'h142);
		i_serial_peer.send(10'h242, 10);
		apb(0, OFF_STAT, 0);
		cmp(rd, 32'h5);
	endtask

	task automatic s_loop();
		apb(1, OFF_CTRL, 32'h181);
		apb(1, OFF_TXBUF, 32'h96);
		wait_irq(1, 400);
		apb(0, OFF_RXBUF, 0);
		cmp(rd, 32'h96);
	endtask

	// Sync word: data taken at each rising shift clock edge
	task automatic s_sync();
		logic [7:0] w;
		logic       pv;
		int         n;
		apb(1, OFF_CTRL, 32'h3);
		apb(1, OFF_TXBUF, 32'hb4);
		n = 0;
		pv = 1'b1;
		w = 8'h00;
		for (int i = 0; i < 300; i++) begin
			@(negedge clk);
			if (pv === 1'b0 && txd === 1'b1 && rxdOeN === 1'b0) begin
				w = {rxdOut, w[7:1]};
				n++;
			end
			pv = txd;
		end
		cmp({24'h0, w}, 32'hb4);
		cmp(n, 8);
		// Sync receive from the idle data line; pin must stay released
		apb(1, OFF_CTRL, 32'h103);
		wait_irq(2, 200);
		cmp({31'h0, rxdOeN}, 32'h1);
		apb(0, OFF_RXBUF, 0);
		cmp(rd, 32'hff);
		apb(1, OFF_CTRL, 0);
	endtask

	// Low run of bits 1 to 7 of word 01: seven bit times; both ends sit
	// on baud ticks, so the start bit's tick phase does not enter
	task automatic s_baud(input logic [31:0] rl, fr, ct, input int exp);
		int k;
		apb(1, OFF_BAUD, rl);
		apb(1, OFF_FRAC, fr);
		apb(1, OFF_CTRL, ct);
		apb(1, OFF_TXBUF, 32'h1);
		k = 0;
		wait_txd(1'b0, 50);
		wait_txd(1'b1, 2000);
		wait_txd(1'b0, 2000);
		while (txd === 1'b0 && k < 2000) begin
			@(negedge clk);
			k++;
		end
		cmp(k, exp);
		wait_irq(1, 2000);
	endtask

	// Reset, then the scenarios in turn
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		s_reset();
		s_tx();
		s_rx();
		s_parity();
		s_mproc();
		s_loop();
		s_sync();
		s_baud(0, 0, 32'h1, 112);
		s_baud(2, 0, 32'h1, 336);
		s_baud(0, 512, 32'h201, 224);
		print_verdict();
	end
endmodule // tb_top
